// file: core/rst_seq_pkg.sv
// Purpose: shared constants for the reset sequencer and cause recorder
// Assumes: pclk is the oscillator reference clock at 250 MHz
// Notes:   cause register sits at byte offset 0x0 of a small apb window
package rst_seq_pkg;
  localparam int          CLK_MHZ         = 250;
  localparam int          STAB_CYCLES     = 4096;
  localparam int          PIN_DRIVE_CYC   = 32;
  localparam int          HOLD_EXTRA_CYC  = 32;
  localparam int          CPU_RELEASE_CYC = 64;
  localparam int          SAMPLE_CYC      = 32;
  localparam int          MIN_LOW_CYC     = 4;
  localparam int          WDOG_TIMEOUT    = 262144;
  localparam logic [15:0] VEC_HI_ADDR     = 16'hFFFE;
  localparam logic [15:0] VEC_LO_ADDR     = 16'hFFFF;
  localparam logic [15:0] WDOG_CTRL_ADDR  = 16'hFFFF;
  localparam logic [7:0]  STOP_OPCODE     = 8'h8E;
  localparam logic [11:0] CAUSE_OFFSET    = 12'h000;
  localparam logic [11:0] CTRL_OFFSET     = 12'h004;
  localparam logic [7:0]  CAUSE_RESET     = 8'h80;
  localparam int          BIT_POWER_ON    = 7;
  localparam int          BIT_EXT_PIN     = 6;
  localparam int          BIT_WATCHDOG    = 5;
  localparam int          BIT_BAD_OPCODE  = 4;
  localparam int          BIT_BAD_FETCH   = 3;
  localparam int          BIT_MONITOR     = 2;
  localparam int          BIT_LOW_SUPPLY  = 1;
  localparam int          BIT_STOP_EN     = 0;

  typedef enum logic [2:0] {
    ST_RUN   = 3'b000,
    ST_STAB  = 3'b001,
    ST_DRIVE = 3'b011,
    ST_HOLD  = 3'b010,
    ST_VEC_H = 3'b110,
    ST_VEC_L = 3'b111,
    ST_LOW   = 3'b101
  } seq_state_t;
endpackage : rst_seq_pkg

// file: core/reset_sequencer_status.sv
// Purpose: reset source gathering, reset pin drive, release timing and cause register
// Assumes: power-on is a raw asynchronous level; cpu events are single-cycle pulses on pclk
// Notes:   all timing counted in pclk cycles (the oscillator reference clock)
`timescale 1ns/1ps
module reset_sequencer_status
  import rst_seq_pkg::*;
#(
  parameter int STAB_COUNT = STAB_CYCLES,
  parameter int WDOG_COUNT = WDOG_TIMEOUT
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rst_pin_in,
  output logic             rst_pin_out,
  output logic             rst_pin_oe,
  input  wire logic        supply_low,
  input  wire logic        illegal_opcode,
  input  wire logic [7:0]  opcode,
  input  wire logic        opcode_valid,
  input  wire logic        fetch_unmapped,
  input  wire logic        data_unmapped,
  input  wire logic        monitor_entry,
  input  wire logic        cpu_wr,
  input  wire logic [15:0] cpu_addr,
  output logic             cpu_reset,
  output logic             cpu_abort,
  output logic             clocks_gated,
  output logic             bus_clk_div4,
  output logic             vec_fetch,
  output logic [15:0]      vec_addr,
  output logic             vec_high_byte
);
  import rst_seq_pkg::*;

  localparam int CW = $clog2(STAB_COUNT + 1);
  localparam int WW = $clog2(WDOG_COUNT + 1);

  // pin synchroniser; only the second stage is read
  logic pin_s1_r, pin_s2_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_r <= 1'b1;
      pin_s2_r <= 1'b1;
    end else begin
      pin_s1_r <= rst_pin_in;
      pin_s2_r <= pin_s1_r;
    end
  end

  // supply-low level also arrives asynchronously
  logic lv_s1_r, lv_s2_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lv_s1_r <= 1'b0;
      lv_s2_r <= 1'b0;
    end else begin
      lv_s1_r <= supply_low;
      lv_s2_r <= lv_s1_r;
    end
  end

  logic        stop_en_r, stop_en_nxt;
  logic [WW-1:0] wdog_r, wdog_nxt;
  logic [2:0]  low_cnt_r, low_cnt_nxt;
  logic        wr_acc, rd_cause, wdog_ovf, ext_req, bad_op, int_req;
  seq_state_t  state_r, state_nxt;
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic [5:0]  smp_r, smp_nxt;
  logic        smp_run_r, smp_run_nxt;
  logic [7:0]  cause_r, cause_nxt;
  logic [7:0]  cause_set;
  logic        por_done_r;
  logic [31:0] prdata_nxt;

  assign pready   = 1'b1;
  assign pslverr  = 1'b0;
  assign wr_acc   = psel && penable && pwrite;
  assign rd_cause = psel && penable && !pwrite && (paddr == CAUSE_OFFSET);

  // power-on: presetn itself is the power-on pulse; first cycle after release starts stabilisation
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) por_done_r <= 1'b0;
    else          por_done_r <= 1'b1;
  end

  // stop option, external-pin qualification and watchdog
  assign bad_op   = illegal_opcode || (opcode_valid && !stop_en_r && opcode == STOP_OPCODE);
  assign wdog_ovf = (wdog_r == WW'(WDOG_COUNT - 1));
  assign ext_req  = (low_cnt_r == 3'(MIN_LOW_CYC - 1)) && !pin_s2_r && !rst_pin_oe;
  // data_unmapped deliberately takes no part: data accesses never reset
  assign int_req  = state_r == ST_RUN &&
                    (wdog_ovf || bad_op || fetch_unmapped || monitor_entry);

  // stop-enable option, written through the control word
  always_comb begin
    stop_en_nxt = stop_en_r;
    if (wr_acc && paddr == CTRL_OFFSET && pstrb[0]) begin
      stop_en_nxt = pwdata[BIT_STOP_EN];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) stop_en_r <= 1'b0;
    else          stop_en_r <= stop_en_nxt;
  end

  // consecutive low samples of the pin while we are not driving it ourselves
  always_comb begin
    low_cnt_nxt = low_cnt_r;
    if (pin_s2_r || rst_pin_oe) begin
      low_cnt_nxt = 3'd0;
    end else if (low_cnt_r != 3'(MIN_LOW_CYC - 1)) begin
      low_cnt_nxt = low_cnt_r + 3'd1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) low_cnt_r <= 3'd0;
    else          low_cnt_r <= low_cnt_nxt;
  end

  // watchdog is held clear in reset so each run starts a full timeout window
  always_comb begin
    wdog_nxt = wdog_r + WW'(1);
    if (cpu_reset || (cpu_wr && cpu_addr == WDOG_CTRL_ADDR) || wdog_ovf) begin
      wdog_nxt = '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) wdog_r <= '0;
    else          wdog_r <= wdog_nxt;
  end

  // sequence: LOW -> STAB -> DRIVE -> HOLD -> VEC_H -> VEC_L -> RUN
  always_comb begin
    state_nxt   = state_r;
    cnt_nxt     = cnt_r + CW'(1);
    smp_nxt     = smp_r;
    smp_run_nxt = smp_run_r;
    cause_set   = 8'h00;
    if (smp_run_r) begin
      smp_nxt = smp_r + 6'd1;
      if (smp_r == 6'(SAMPLE_CYC - 1)) begin
        smp_run_nxt = 1'b0;
        if (!pin_s2_r) cause_set[BIT_EXT_PIN] = 1'b1;
      end
    end
    unique case (state_r)
      ST_RUN: begin
        cnt_nxt = '0;
        if (lv_s2_r) begin
          state_nxt = ST_LOW;
          cause_set[BIT_LOW_SUPPLY] = 1'b1;
        end else if (int_req) begin
          state_nxt = ST_DRIVE;
          if (wdog_ovf)       cause_set[BIT_WATCHDOG]   = 1'b1;
          if (bad_op)         cause_set[BIT_BAD_OPCODE] = 1'b1;
          if (fetch_unmapped) cause_set[BIT_BAD_FETCH]  = 1'b1;
          if (monitor_entry)  cause_set[BIT_MONITOR]    = 1'b1;
        end else if (ext_req) begin
          state_nxt = ST_HOLD;
          cause_set[BIT_EXT_PIN] = 1'b1;
        end
      end
      ST_LOW: begin
        cnt_nxt = '0;
        if (!lv_s2_r) state_nxt = ST_STAB;
      end
      ST_STAB: begin
        if (lv_s2_r) state_nxt = ST_LOW;
        else if (cnt_r == CW'(STAB_COUNT - 1)) begin
          state_nxt = ST_DRIVE;
          cnt_nxt   = '0;
        end
      end
      ST_DRIVE: if (cnt_r == CW'(PIN_DRIVE_CYC - 1)) begin
        state_nxt   = ST_HOLD;
        cnt_nxt     = '0;
        smp_run_nxt = 1'b1;
        smp_nxt     = 6'd0;
      end
      ST_HOLD: begin
        // an external reset holds while the pin stays low
        if (!pin_s2_r && !rst_pin_oe) cnt_nxt = '0;
        else if (cnt_r == CW'(HOLD_EXTRA_CYC - 1)) begin
          state_nxt = ST_VEC_H;
          cnt_nxt   = '0;
        end
      end
      ST_VEC_H: state_nxt = ST_VEC_L;
      ST_VEC_L: state_nxt = ST_RUN;
      default:  state_nxt = ST_RUN;
    endcase
    // power-on overrides everything in its first cycle
    if (!por_done_r) begin
      state_nxt   = ST_STAB;
      cnt_nxt     = '0;
      smp_run_nxt = 1'b0;
    end
  end

  // per-flag update: a read clears only the bits it reported, so a cause latched
  // between the setup and access edges survives; a set in the clearing edge wins
  for (genvar b = 0; b < 8; b++) begin : g_cause
    if (b == 0) begin : g_zero
      assign cause_nxt[b] = 1'b0;
    end else begin : g_flag
      assign cause_nxt[b] = !por_done_r ? ((b == BIT_POWER_ON) || (b == BIT_LOW_SUPPLY)) :
                            (cause_set[b] || (cause_r[b] && !(rd_cause && prdata[b])));
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r   <= ST_STAB;
      cnt_r     <= '0;
      smp_r     <= 6'd0;
      smp_run_r <= 1'b0;
      cause_r   <= CAUSE_RESET;
    end else begin
      state_r   <= state_nxt;
      cnt_r     <= cnt_nxt;
      smp_r     <= smp_nxt;
      smp_run_r <= smp_run_nxt;
      cause_r   <= cause_nxt;
    end
  end

  // pin, clock-gate and vector outputs decoded from the state register only, so they never glitch on inputs
  logic        pin_drive;
  logic        gate_clk;
  logic        in_vec;
  logic        vec_hi;
  logic [15:0] vec_sel;

  always_comb begin
    pin_drive = 1'b0;
    gate_clk  = 1'b0;
    in_vec    = 1'b0;
    vec_hi    = 1'b0;
    vec_sel   = VEC_HI_ADDR;
    unique case (state_r)
      ST_RUN: begin
        pin_drive = 1'b0;
        gate_clk  = 1'b0;
        in_vec    = 1'b0;
        vec_hi    = 1'b0;
        vec_sel   = VEC_HI_ADDR;
      end
      ST_LOW: begin
        pin_drive = 1'b1;
        gate_clk  = 1'b1;
        in_vec    = 1'b0;
        vec_hi    = 1'b0;
        vec_sel   = VEC_HI_ADDR;
      end
      ST_STAB: begin
        pin_drive = 1'b1;
        gate_clk  = 1'b1;
        in_vec    = 1'b0;
        vec_hi    = 1'b0;
        vec_sel   = VEC_HI_ADDR;
      end
      ST_DRIVE: begin
        pin_drive = 1'b1;
        gate_clk  = 1'b0;
        in_vec    = 1'b0;
        vec_hi    = 1'b0;
        vec_sel   = VEC_HI_ADDR;
      end
      ST_HOLD: begin
        pin_drive = 1'b0;
        gate_clk  = 1'b0;
        in_vec    = 1'b0;
        vec_hi    = 1'b0;
        vec_sel   = VEC_HI_ADDR;
      end
      ST_VEC_H: begin
        pin_drive = 1'b0;
        gate_clk  = 1'b0;
        in_vec    = 1'b1;
        vec_hi    = 1'b1;
        vec_sel   = VEC_HI_ADDR;
      end
      ST_VEC_L: begin
        pin_drive = 1'b0;
        gate_clk  = 1'b0;
        in_vec    = 1'b1;
        vec_hi    = 1'b0;
        vec_sel   = VEC_LO_ADDR;
      end
      default: begin
        // unused code: keep the pin low so outside parts stay in reset
        pin_drive = 1'b1;
        gate_clk  = 1'b0;
        in_vec    = 1'b0;
        vec_hi    = 1'b0;
        vec_sel   = VEC_HI_ADDR;
      end
    endcase
  end

  assign rst_pin_out   = 1'b0;
  assign rst_pin_oe    = pin_drive;
  assign cpu_reset     = (state_r != ST_RUN) || int_req || ext_req || lv_s2_r;
  assign cpu_abort     = cpu_reset;
  assign clocks_gated  = gate_clk;
  assign bus_clk_div4  = cpu_reset;
  assign vec_fetch     = in_vec;
  assign vec_high_byte = vec_hi;
  assign vec_addr      = vec_sel;

  always_comb begin
    prdata_nxt = 32'h0000_0000;
    if (psel && !pwrite) begin
      if (paddr == CAUSE_OFFSET)     prdata_nxt = {24'h00_0000, cause_r};
      else if (paddr == CTRL_OFFSET) prdata_nxt = {31'h0, stop_en_r};
    end
  end

  // read data registered in the setup cycle so it is stable during access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata <= 32'h0000_0000;
    else          prdata <= prdata_nxt;
  end

endmodule : reset_sequencer_status

// file: sim/rst_seq_checker.sv
// Purpose: concurrent checks on the reset sequencer pins
// Assumes: one pclk domain, presetn async active low
// Notes:   run counters replace long repetitions
`timescale 1ns/1ps
module rst_seq_checker #(
  parameter int STAB_COUNT = 16
) (
  input logic        pclk,
  input logic        presetn,
  input logic        rst_pin_in,
  input logic        rst_pin_out,
  input logic        rst_pin_oe,
  input logic        illegal_opcode,
  input logic        fetch_unmapped,
  input logic        monitor_entry,
  input logic        data_unmapped,
  input logic        cpu_reset,
  input logic        cpu_abort,
  input logic        clocks_gated,
  input logic        bus_clk_div4,
  input logic        vec_fetch,
  input logic [15:0] vec_addr,
  input logic        vec_high_byte
);
  logic [15:0] oe_cnt_r, oe_cnt_nxt, gate_cnt_r, gate_cnt_nxt;
  logic        ev;
  assign ev = illegal_opcode || fetch_unmapped || monitor_entry;
  always_comb begin
    oe_cnt_nxt   = rst_pin_oe ? oe_cnt_r + 16'h0001 : 16'h0000;
    gate_cnt_nxt = clocks_gated ? gate_cnt_r + 16'h0001 : 16'h0000;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oe_cnt_r   <= 16'h0000;
      gate_cnt_r <= 16'h0000;
    end else begin
      oe_cnt_r   <= oe_cnt_nxt;
      gate_cnt_r <= gate_cnt_nxt;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  abort_at_once_a: assert property (ev && !$past(cpu_reset) |-> cpu_abort && cpu_reset)
    else $error("reset event did not abort at once");
  vec_order_a: assert property (vec_fetch && vec_high_byte |-> vec_addr == 16'hFFFE ##1
    vec_fetch && !vec_high_byte && vec_addr == 16'hFFFF) else $error("vector fetch order wrong");
  div4_in_reset_a: assert property (cpu_reset |-> bus_clk_div4)
    else $error("bus clock not div4 in reset");
  pin_only_low_a: assert property (rst_pin_oe |-> !rst_pin_out)
    else $error("reset pin driven high");
  drive_len_a: assert property ($fell(rst_pin_oe) |-> oe_cnt_r >= 16'h0020)
    else $error("reset pin drive too short");
  hold_after_a: assert property ($fell(rst_pin_oe) |-> cpu_reset [*8] ##23 cpu_reset)
    else $error("cpu released too soon after pin");
  vec_soon_a: assert property ($fell(rst_pin_oe) |-> ##[32:1000] vec_fetch && vec_high_byte)
    else $error("vector fetch missing after pin release");
  gate_len_a: assert property ($fell(clocks_gated) |-> gate_cnt_r >= STAB_COUNT)
    else $error("clock gating too short");
  gate_drives_a: assert property (clocks_gated |-> rst_pin_oe && cpu_reset)
    else $error("pin not driven while clocks gated");
  data_ignore_a: assert property (data_unmapped && !ev && rst_pin_in && !$past(cpu_reset) |-> !cpu_reset)
    else $error("data access caused reset");
  pin_sync_a: assert property ($fell(rst_pin_in) && !rst_pin_oe && !cpu_reset |=> !cpu_reset || ev)
    else $error("pin acted without synchroniser");
endmodule : rst_seq_checker
bind reset_sequencer_status rst_seq_checker #(.STAB_COUNT(STAB_COUNT)) u_chk (.pclk, .presetn, .rst_pin_in,
  .rst_pin_out, .rst_pin_oe, .illegal_opcode, .fetch_unmapped, .monitor_entry, .data_unmapped, .cpu_reset,
  .cpu_abort, .clocks_gated, .bus_clk_div4, .vec_fetch, .vec_addr, .vec_high_byte);

// file: sim/reset_pin_ext.sv
// Purpose: external circuit on the open-drain reset pin
// Assumes: pull-up on the wire, so released reads high
// Notes:   slow_en mimics a slow external device holding the pin
`timescale 1ns/1ps
module reset_pin_ext #(
  parameter int SLOW_CYC = 40
) (
  input  logic pclk,
  input  logic presetn,
  input  logic rst_pin_out,
  input  logic rst_pin_oe,
  input  logic ext_hold,
  input  logic slow_en,
  output logic pin_level
);
  logic [7:0] slow_r, slow_nxt;
  always_comb begin
    slow_nxt = slow_r;
    if (rst_pin_oe && slow_en) slow_nxt = 8'(SLOW_CYC);
    else if (slow_r != 8'h00) slow_nxt = slow_r - 8'h01;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) slow_r <= 8'h00;
    else slow_r <= slow_nxt;
  end
  assign pin_level = !((rst_pin_oe && !rst_pin_out) || ext_hold || slow_r != 8'h00);
endmodule : reset_pin_ext

// file: sim/reset_sequencer_status_test.sv
// Purpose: apb driven bench for reset sequencing and cause flags
// Assumes: short stabilisation and watchdog counts
// Notes:   cpu_wr held high keeps the watchdog quiet between tests
`timescale 1ns/1ps
module reset_sequencer_status_test;
  import rst_seq_pkg::*;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        supply_low = 1'b0, data_unmapped = 1'b0, opcode_valid = 1'b0, cpu_wr = 1'b1;
  logic        ext_hold = 1'b0, slow_en = 1'b0, pin, pready, pslverr, rst_pin_out, rst_pin_oe;
  logic        cpu_reset, cpu_abort, clocks_gated, bus_clk_div4, vec_fetch, vec_high_byte;
  logic [2:0]  ev = 3'h0;
  logic [3:0]  pstrb = 4'hF;
  logic [7:0]  opcode = 8'h00;
  logic [11:0] paddr = 12'h000;
  logic [15:0] cpu_addr = WDOG_CTRL_ADDR, vec_addr;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  int          err_count = 0, checked = 0, n;
  int          bitpos [3] = '{BIT_BAD_OPCODE, BIT_BAD_FETCH, BIT_MONITOR};
  initial begin forever #2 pclk = ~pclk; end
  reset_sequencer_status #(.STAB_COUNT(16), .WDOG_COUNT(64)) uut (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .rst_pin_in(pin), .rst_pin_out, .rst_pin_oe,
    .supply_low, .illegal_opcode(ev[0]), .opcode, .opcode_valid, .fetch_unmapped(ev[1]), .data_unmapped,
    .monitor_entry(ev[2]), .cpu_wr, .cpu_addr, .cpu_reset, .cpu_abort, .clocks_gated, .bus_clk_div4,
    .vec_fetch, .vec_addr, .vec_high_byte);
  reset_pin_ext ext (.pclk, .presetn, .rst_pin_out, .rst_pin_oe, .ext_hold, .slow_en, .pin_level(pin));
  task summarize;
    if (err_count == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : summarize
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin chk(pready, 1); summarize(); end
  endtask : apb
  // bounded wait for cpu_reset to reach a level
  task wait_lvl(input logic v);
    for (n = 0; n < 3000 && cpu_reset !== v; n++) @(posedge pclk);
    if (cpu_reset !== v) begin chk(cpu_reset, v); summarize(); end
  endtask : wait_lvl
  task rd_cause(input logic [7:0] e);
    apb(1'b0, CAUSE_OFFSET, 32'h0);
    chk(rd, {24'h0, e});
    chk(pslverr, 32'h0);
  endtask : rd_cause
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    wait_lvl(1'b0);
    rd_cause(8'((1 << BIT_POWER_ON) | (1 << BIT_LOW_SUPPLY)));
    apb(1'b1, CAUSE_OFFSET, 32'h0000_00FF);
    rd_cause(8'h00);
    apb(1'b0, 12'h0F0, 32'h0);
    chk(rd, 32'h0);
    for (int k = 0; k < 3; k++) begin
      ev <= 3'(1 << k);
      @(posedge pclk);
      ev <= 3'h0;
      wait_lvl(1'b0);
      rd_cause(8'(1 << bitpos[k]));
    end
    data_unmapped <= 1'b1;
    repeat (4) @(posedge pclk);
    data_unmapped <= 1'b0;
    chk(cpu_reset, 32'h0);
    // stop allowed first, then refused as an illegal opcode
    for (int s = 1; s >= 0; s--) begin
      apb(1'b1, CTRL_OFFSET, 32'(s));
      opcode <= STOP_OPCODE;
      opcode_valid <= 1'b1;
      @(posedge pclk);
      opcode_valid <= 1'b0;
      @(posedge pclk);
      chk(cpu_reset, 32'(1 - s));
      wait_lvl(1'b0);
    end
    rd_cause(8'(1 << BIT_BAD_OPCODE));
    repeat (200) @(posedge pclk);
    chk(cpu_reset, 32'h0);
    cpu_wr <= 1'b0;
    wait_lvl(1'b1);
    cpu_wr <= 1'b1;
    wait_lvl(1'b0);
    rd_cause(8'(1 << BIT_WATCHDOG));
    ext_hold <= 1'b1;
    repeat (10) @(posedge pclk);
    chk(cpu_reset, 32'h1);
    ext_hold <= 1'b0;
    wait_lvl(1'b0);
    rd_cause(8'(1 << BIT_EXT_PIN));
    slow_en <= 1'b1;
    ev <= 3'b100;
    @(posedge pclk);
    ev <= 3'h0;
    wait_lvl(1'b0);
    slow_en <= 1'b0;
    rd_cause(8'((1 << BIT_EXT_PIN) | (1 << BIT_MONITOR)));
    supply_low <= 1'b1;
    repeat (20) @(posedge pclk);
    chk({clocks_gated, rst_pin_oe}, 32'h3);
    supply_low <= 1'b0;
    wait_lvl(1'b0);
    rd_cause(8'(1 << BIT_LOW_SUPPLY));
    summarize();
  end
endmodule : reset_sequencer_status_test
